/* src/plsyn_core.v */
// Synthesizer digital core: mode, divider, reference, comparator, unlock
// How it works
// - Synth runs only while chip enable high
// - Mode bits 1:0 pick reference frequency
// - Mode bits 3:2 pick input and method
// - Unlock judge bit 0 shows unlock flag
// - 4-bit swallow and 12-bit programmable counters
// - Direct mode: low-band input, programmable only
// - Direct mode loads upper 12 bits only
// - Swallow modes use all 16 bits
// - Lower swallow: low-band input, both counters
// - Upper swallow: high-band input, low floats
// - Both disabled: everything stops, output floats
// - Divide value at peripheral address 41H
// - Reference 1, 3, 5 or 25 kHz
// - Up when lagging, down when leading
// - No requests while disabled
// - Error output low, high or float
// - Unlock set per reference period on request
// - Reading 6DH returns flag then clears
// - Method code zero disables synthesizer
// - Mode reset only on power-on or clock-stop
`timescale 1ns/10ps
`include "plsyn_defs.vh"
module plsyn_core
(
  // Clock and power-on reset
  input wire i_mclk,
  input wire i_rstn,
  // Chip enable pin and clock-stop event
  input wire i_chip_enable,
  input wire i_clock_stop,
  // Peripheral transfer port (transfer buffer moves)
  input wire [7:0] i_periph_addr,
  input wire i_periph_put,
  input wire i_periph_get,
  input wire [15:0] i_transfer_buffer,
  output reg [15:0] o_transfer_buffer,
  // Data memory port for mode and unlock judge
  input wire i_mode_wr,
  input wire [3:0] i_mode_wdata,
  input wire [7:0] i_data_addr,
  input wire i_data_rd,
  output reg [3:0] o_data_rdata,
  output reg [3:0] o_mode_rdata,
  // Band inputs, as digital edges from input amplifiers
  input wire i_low_band_input,
  input wire i_high_band_input,
  output reg o_low_band_enable,
  output reg o_high_band_enable,
  // Error output pin, two signals for three states
  output reg o_error_output,
  output reg o_error_output_oe,
  // Comparator requests, active low
  output reg o_up_request_n,
  output reg o_down_request_n
);
  reg [15:0] synth_divide_value_q;
  reg [3:0] synth_mode_select_q;
  reg unlock_status_flag_q;
  reg ce_s1_q, ce_s2_q;
  reg up_q, down_q;
  reg direct_division_mode;
  reg lower_swallow_mode;
  reg upper_swallow_mode;
  wire [1:0] method_select_field;
  wire run;
  wire [1:0] band_pin;
  wire [1:0] band_edge;
  wire tick;
  genvar b;
  wire [15:0] nval;
  wire fn_pulse;
  wire fr_pulse;
  wire unlock_rd;

  assign method_select_field = synth_mode_select_q[`PLSYN_METHOD_LSB +: 2];
  assign run = ce_s2_q && (method_select_field != `PLSYN_METHOD_OFF);
  // Method decode; code zero leaves every mode flag low
  always @*
  begin
    direct_division_mode = 1'b0;
    lower_swallow_mode = 1'b0;
    upper_swallow_mode = 1'b0;
    case (method_select_field)
      `PLSYN_METHOD_DIRECT: direct_division_mode = 1'b1;
      `PLSYN_METHOD_LOWSW: lower_swallow_mode = 1'b1;
      `PLSYN_METHOD_UPSW: upper_swallow_mode = 1'b1;
      default: ;
    endcase
  end
  // Edge of the selected band only; the unused band is ignored
  assign tick = upper_swallow_mode ? band_edge[1] : band_edge[0];
  // Direct mode keeps the low nibble out of the count
  // Swallow modes hand all 16 bits to the divider
  assign nval = direct_division_mode ? {synth_divide_value_q[15:4], 4'h0} : synth_divide_value_q;
  assign unlock_rd = i_data_rd && (i_data_addr == `PLSYN_ADDR_UNLOCK);

  // Two-flop synchroniser for the chip enable pin
  always @(posedge i_mclk)
  begin
    if (!i_rstn)
    begin
      ce_s1_q <= 1'b0;
      ce_s2_q <= 1'b0;
    end
    else
    begin
      ce_s1_q <= i_chip_enable;
      ce_s2_q <= ce_s1_q;
    end
  end

  // Band pins: bit 0 low band, bit 1 high band
  assign band_pin = {i_high_band_input, i_low_band_input};

  // Per band: two sync flops, then a third for the edge
  // Band rate must stay below a quarter of the clock or edges merge
  generate
    for (b = 0; b < 2; b = b + 1)
    begin : g_band
      reg s1_q;
      reg s2_q;
      reg s3_q;
      always @(posedge i_mclk)
      begin
        if (!i_rstn)
        begin
          s1_q <= 1'b0;
          s2_q <= 1'b0;
          s3_q <= 1'b0;
        end
        else
        begin
          s1_q <= band_pin[b];
          s2_q <= s1_q;
          s3_q <= s2_q;
        end
      end
      // Rising edge of the synchronised level
      assign band_edge[b] = s2_q & ~s3_q;
    end
  endgenerate

  // Divide value register and transfer read-back
  // A new value takes effect at the next divider reload, not mid-count
  always @(posedge i_mclk)
  begin
    if (!i_rstn)
    begin
      synth_divide_value_q <= 16'h0000;
      o_transfer_buffer <= 16'h0000;
    end
    else
    begin
      if (i_periph_put && i_periph_addr == `PLSYN_ADDR_DIVIDE)
        synth_divide_value_q <= i_transfer_buffer;
      if (i_periph_get && i_periph_addr == `PLSYN_ADDR_DIVIDE)
        o_transfer_buffer <= synth_divide_value_q;
    end
  end

  // Mode register; chip enable alone does not clear it
  // Clock stop clears it just as power-on reset does
  always @(posedge i_mclk)
  begin
    if (!i_rstn || i_clock_stop)
      synth_mode_select_q <= `PLSYN_MODE_RESET;
    else if (i_mode_wr)
      synth_mode_select_q <= i_mode_wdata;
  end

  // Programmable divider
  plsyn_divider u_div
  (
    .i_mclk(i_mclk),
    .i_rstn(i_rstn),
    .i_run(run),
    .i_swallow(lower_swallow_mode | upper_swallow_mode),
    .i_nval(nval),
    .i_tick(tick),
    .o_fn_pulse(fn_pulse)
  );

  // Reference generator
  // Restarts from zero whenever the synthesizer stops
  plsyn_refgen u_ref
  (
    .i_mclk(i_mclk),
    .i_rstn(i_rstn),
    .i_run(run),
    .i_ref_sel(synth_mode_select_q[`PLSYN_REFSEL_LSB +: 2]),
    .o_fr_pulse(fr_pulse)
  );

  // Phase-frequency detector: first edge raises its request, second clears both
  // Coincident edges count as in phase, so neither request is raised
  // Requests stay exclusive, which keeps the error pin drive simple
  always @(posedge i_mclk)
  begin
    if (!i_rstn || !run)
    begin
      up_q <= 1'b0;
      down_q <= 1'b0;
    end
    else if (fr_pulse && fn_pulse)
    begin
      up_q <= 1'b0;
      down_q <= 1'b0;
    end
    else if (fr_pulse)
    begin
      if (down_q)
        down_q <= 1'b0;
      else
        up_q <= 1'b1;
    end
    else if (fn_pulse)
    begin
      if (up_q)
        up_q <= 1'b0;
      else
        down_q <= 1'b1;
    end
  end

  // Requests from flops; both idle while disabled
  always @(posedge i_mclk)
  begin
    if (!i_rstn)
    begin
      o_up_request_n <= 1'b1;
      o_down_request_n <= 1'b1;
    end
    else
    begin
      o_up_request_n <= ~(up_q & run);
      o_down_request_n <= ~(down_q & run);
    end
  end

  // Error pin: driven only while exactly one request stands
  always @(posedge i_mclk)
  begin
    if (!i_rstn)
    begin
      o_error_output <= 1'b0;
      o_error_output_oe <= 1'b0;
    end
    else
    begin
      o_error_output <= down_q;
      o_error_output_oe <= run & (up_q ^ down_q);
    end
  end

  // Band enables; an unused pin floats so its amplifier idles
  always @(posedge i_mclk)
  begin
    if (!i_rstn)
    begin
      o_low_band_enable <= 1'b0;
      o_high_band_enable <= 1'b0;
    end
    else
    begin
      o_low_band_enable <= run & (direct_division_mode | lower_swallow_mode);
      o_high_band_enable <= run & upper_swallow_mode;
    end
  end

  // Unlock flag; a set in the read cycle survives the clear
  // Polling slower than one reference period never misses a set
  always @(posedge i_mclk)
  begin
    if (!i_rstn)
      unlock_status_flag_q <= 1'b0;
    else if (run && fr_pulse && (up_q || down_q))
      unlock_status_flag_q <= 1'b1;
    else if (unlock_rd)
      unlock_status_flag_q <= 1'b0;
  end

  // Read data for the data-memory port
  // Judge reads as zero on any other address
  always @(posedge i_mclk)
  begin
    if (!i_rstn)
    begin
      o_data_rdata <= 4'h0;
      o_mode_rdata <= 4'h0;
    end
    else
    begin
      o_data_rdata <= unlock_rd ? {3'b000, unlock_status_flag_q} : 4'h0;
      o_mode_rdata <= synth_mode_select_q;
    end
  end
endmodule // plsyn_core

/* src/plsyn_defs.vh */
// Constants for the synthesizer digital core
`ifndef PLSYN_DEFS_VH
`define PLSYN_DEFS_VH
`define PLSYN_ADDR_DIVIDE 8'h41
`define PLSYN_ADDR_UNLOCK 8'h6D
`define PLSYN_MODE_RESET 4'h0
`define PLSYN_REFSEL_LSB 0
`define PLSYN_METHOD_LSB 2
`define PLSYN_METHOD_OFF 2'h0
`define PLSYN_METHOD_DIRECT 2'h1
`define PLSYN_METHOD_LOWSW 2'h2
`define PLSYN_METHOD_UPSW 2'h3
// Reference divisors at the 125 MHz clock; 3 kHz rounds up
`define PLSYN_REF_DIV_1K 17'h1E848
`define PLSYN_REF_DIV_3K 17'h0A2C3
`define PLSYN_REF_DIV_5K 17'h061A8
`define PLSYN_REF_DIV_25K 17'h01388
// Last count of the 16/17 prescaler at modulus 16
`define PLSYN_PRESCALE_LAST 5'h0F
`endif

/* src/plsyn_divider.v */
// Programmable divider: swallow counter plus programmable counter
`timescale 1ns/10ps
`include "plsyn_defs.vh"
module plsyn_divider
(
  // Clock and reset
  input wire i_mclk,
  input wire i_rstn,
  // Control
  input wire i_run,
  input wire i_swallow,
  input wire [15:0] i_nval,
  // Synchronised input edge
  input wire i_tick,
  // Divided pulse
  output reg o_fn_pulse
);
  reg [11:0] prog_q;
  reg [3:0] swal_q;
  reg [4:0] pre_q;
  wire [4:0] pre_last;
  wire pre_wrap;
  // Prescaler stretches to 17 while swallows remain, else 16
  assign pre_last = `PLSYN_PRESCALE_LAST + {4'h0, swal_q != 4'h0};
  // Direct mode counts every edge; swallow modes count prescaler wraps
  assign pre_wrap = !i_swallow || (pre_q == pre_last);
  // Swallow: 16 * upper + lower edges per pulse; direct: upper only
  always @(posedge i_mclk)
  begin
    if (!i_rstn)
    begin
      prog_q <= 12'h000;
      swal_q <= 4'h0;
      pre_q <= 5'h00;
      o_fn_pulse <= 1'b0;
    end
    else if (!i_run)
    begin
      // Preload so the first pulse comes one full period after start
      prog_q <= i_nval[15:4];
      swal_q <= i_swallow ? i_nval[3:0] : 4'h0;
      pre_q <= 5'h00;
      o_fn_pulse <= 1'b0;
    end
    else
    begin
      o_fn_pulse <= 1'b0;
      if (i_tick)
      begin
        pre_q <= pre_wrap ? 5'h00 : pre_q + 5'h01;
        if (pre_wrap)
        begin
          if (prog_q <= 12'h001)
          begin
            // Reload; pulse marks one divided period
            prog_q <= i_nval[15:4];
            swal_q <= i_swallow ? i_nval[3:0] : 4'h0;
            o_fn_pulse <= 1'b1;
          end
          else
          begin
            prog_q <= prog_q - 12'h001;
            if (swal_q != 4'h0)
              swal_q <= swal_q - 4'h1;
          end
        end
      end
    end
  end
endmodule // plsyn_divider

/* src/plsyn_refgen.v */
// Reference frequency generator from the system clock
`timescale 1ns/10ps
`include "plsyn_defs.vh"
module plsyn_refgen
(
  // Clock and reset
  input wire i_mclk,
  input wire i_rstn,
  // Control
  input wire i_run,
  input wire [1:0] i_ref_sel,
  // Reference pulse
  output reg o_fr_pulse
);
  reg [16:0] cnt_q;
  reg [16:0] limit;
  // Divide ratio per selection
  always @*
  begin
    case (i_ref_sel)
      2'h0: limit = `PLSYN_REF_DIV_1K;
      2'h1: limit = `PLSYN_REF_DIV_3K;
      2'h2: limit = `PLSYN_REF_DIV_5K;
      default: limit = `PLSYN_REF_DIV_25K;
    endcase
  end
  // Free count, stopped while disabled
  always @(posedge i_mclk)
  begin
    if (!i_rstn || !i_run)
    begin
      cnt_q <= 17'h00000;
      o_fr_pulse <= 1'b0;
    end
    else if (cnt_q >= limit - 17'h00001)
    begin
      cnt_q <= 17'h00000;
      o_fr_pulse <= 1'b1;
    end
    else
    begin
      cnt_q <= cnt_q + 17'h00001;
      o_fr_pulse <= 1'b0;
    end
  end
endmodule // plsyn_refgen

/* verif/plsyn_core_asserts.sv */
// Port checker for the synthesizer core
`timescale 1ns/10ps
module plsyn_core_asserts
(
  // Clock, reset and strobes
  input wire i_mclk, input wire i_rstn, input wire i_chip_enable, input wire i_periph_get, input wire i_data_rd,
  // Observed outputs
  input wire [15:0] o_transfer_buffer, input wire [3:0] o_data_rdata, input wire [3:0] o_mode_rdata,
  input wire o_low_band_enable, input wire o_high_band_enable, input wire o_error_output,
  input wire o_error_output_oe, input wire o_up_request_n, input wire o_down_request_n
);
  reg [2:0] lo_q = 3'h0;
  reg [2:0] hi_q = 3'h0;
  wire [1:0] md = o_mode_rdata[3:2];
  // CE level age, saturating at 7 so it outlasts the synchroniser
  always @(posedge i_mclk)
  begin
    lo_q <= i_chip_enable ? 3'h0 : lo_q + {2'h0, lo_q != 3'h7};
    hi_q <= !i_chip_enable ? 3'h0 : hi_q + {2'h0, hi_q != 3'h7};
  end
  default clocking @(posedge i_mclk); endclocking
  default disable iff (!i_rstn);
  ce_low_idle_a:
    assert property (lo_q == 3'h7 |-> !o_error_output_oe && o_up_request_n && o_down_request_n && !o_low_band_enable
      && !o_high_band_enable) else $error("active while CE low");
  method_off_a:
    assert property (md == 2'h0 [*6] |-> !o_error_output_oe && !o_low_band_enable && !o_high_band_enable)
      else $error("active with method off");
  band_select_a:
    assert property ((hi_q == 3'h7 && md != 2'h0 && $stable(md)) [*6] |-> o_high_band_enable == (md == 2'h3)
      && o_low_band_enable == (md != 2'h3)) else $error("wrong band input");
  err_drive_a:
    assert property (o_up_request_n != o_down_request_n |-> o_error_output_oe && o_error_output == o_up_request_n)
      else $error("error pin disagrees");
  err_float_a:
    assert property (o_up_request_n && o_down_request_n |-> !o_error_output_oe) else $error("error pin driven");
  rd_pulse_a:
    assert property (!i_data_rd |=> o_data_rdata == 4'h0) else $error("read data without read");
  rd_upper_a:
    assert property (i_data_rd |=> o_data_rdata[3:1] == 3'h0) else $error("judge upper bits set");
  xfer_hold_a:
    assert property (!i_periph_get |=> $stable(o_transfer_buffer)) else $error("transfer buffer moved");
  cover property (!o_up_request_n);
  cover property (!o_down_request_n);
  cover property (o_data_rdata[0]);
endmodule // plsyn_core_asserts
bind plsyn_core plsyn_core_asserts plsyn_core_asserts_inst (.i_mclk, .i_rstn, .i_chip_enable, .i_periph_get,
  .i_data_rd, .o_transfer_buffer, .o_data_rdata, .o_mode_rdata, .o_low_band_enable, .o_high_band_enable,
  .o_error_output, .o_error_output_oe, .o_up_request_n, .o_down_request_n);

/* verif/plsyn_vco_model.sv */
// Behavioural VCO for the band inputs
`timescale 1ns/10ps
module plsyn_vco_model
(
  // Clock and half period in cycles, zero stops it
  input wire i_mclk,
  input wire [7:0] i_half,
  // Band signal
  output reg o_wave = 1'h0
);
  reg [7:0] cnt_q = 8'h0;
  // Toggle each half period; callers keep it below a quarter of the clock
  always @(posedge i_mclk)
  begin
    cnt_q <= (cnt_q + 8'h1 >= i_half) ? 8'h0 : cnt_q + 8'h1;
    o_wave <= o_wave ^ (i_half != 8'h0 && cnt_q + 8'h1 >= i_half);
  end
endmodule // plsyn_vco_model

/* verif/plsyn_core_tb.sv */
// Self-checking bench for the synthesizer core
`timescale 1ns/10ps
module plsyn_core_tb;
  reg i_mclk = 1'h0, i_rstn = 1'h0, i_chip_enable = 1'h0, i_clock_stop = 1'h0, i_periph_put = 1'h0;
  reg i_periph_get = 1'h0, i_mode_wr = 1'h0, i_data_rd = 1'h0;
  reg [7:0] i_periph_addr = 8'h0, half = 8'h0;
  reg [15:0] i_transfer_buffer = 16'h0;
  reg [3:0] i_mode_wdata = 4'h0;
  wire [15:0] o_transfer_buffer;
  wire [3:0] o_data_rdata, o_mode_rdata;
  wire wave, o_low_band_enable, o_high_band_enable, o_error_output, o_error_output_oe, o_up_request_n;
  wire o_down_request_n;
  integer n_errors = 0, compares = 0, i, k;
  // 125 MHz clock
  always #4 i_mclk = ~i_mclk;
  plsyn_vco_model plsyn_vco_model_inst (.i_mclk, .i_half(half), .o_wave(wave));
  // Both bands see the same wave; data address shares the peripheral one
  plsyn_core plsyn_core_inst (.i_mclk, .i_rstn, .i_chip_enable, .i_clock_stop, .i_periph_addr, .i_periph_put,
    .i_periph_get, .i_transfer_buffer, .o_transfer_buffer, .i_mode_wr, .i_mode_wdata, .i_data_addr(i_periph_addr),
    .i_data_rd, .o_data_rdata, .o_mode_rdata, .i_low_band_input(wave), .i_high_band_input(wave),
    .o_low_band_enable, .o_high_band_enable, .o_error_output, .o_error_output_oe, .o_up_request_n,
    .o_down_request_n);
  task chk(input logic [15:0] seen, input logic [15:0] exp, input string what);
  begin
    compares = compares + 1;
    if (seen !== exp)
    begin
      n_errors = n_errors + 1;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  end
  endtask
  task print_verdict;
  begin
    $display("compares %0d n_errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  end
  endtask
  // One-cycle strobe: 0 put, 1 get, 2 mode write, 3 data read
  task strobe(input [1:0] sel, input [7:0] a, input [15:0] v);
  begin
    @(posedge i_mclk);
    i_periph_addr <= a;
    i_transfer_buffer <= v;
    i_mode_wdata <= v[3:0];
    i_periph_put <= sel == 2'h0;
    i_periph_get <= sel == 2'h1;
    i_mode_wr <= sel == 2'h2;
    i_data_rd <= sel == 2'h3;
    @(posedge i_mclk);
    {i_periph_put, i_periph_get, i_mode_wr, i_data_rd} <= 4'h0;
    repeat (sel == 2'h2 ? 6 : 0) @(posedge i_mclk);
    #1;
  end
  endtask
  // Bounded wait for a request; running out ends the run
  task wait_req(input dn);
  begin
    for (k = 0; k < 12000 && (dn ? o_down_request_n : o_up_request_n) !== 1'h0; k = k + 1)
      #8;
    if (k == 12000)
    begin
      n_errors = n_errors + 1;
      print_verdict;
    end
  end
  endtask
  initial
  begin
    repeat (16) @(posedge i_mclk);
    i_rstn <= 1'h1;
    i_chip_enable <= 1'h1;
    strobe(2'h0, 8'h41, 16'h1234);
    strobe(2'h0, 8'h42, 16'hFFFF);
    strobe(2'h1, 8'h41, 16'h0);
    chk(o_transfer_buffer, 16'h1234, "divide value");
    strobe(2'h1, 8'h6D, 16'h0);
    chk(o_transfer_buffer, 16'h1234, "unmapped get");
    // Every method and reference code
    for (i = 0; i < 16; i = i + 1)
    begin
      strobe(2'h2, 8'h0, i[15:0]);
      chk(o_mode_rdata, i[3:0], "mode");
      chk(o_low_band_enable, i[3:2] == 2'h1 || i[3:2] == 2'h2, "low band");
      chk(o_high_band_enable, i[3:2] == 2'h3, "high band");
    end
    // Band stopped: divided signal lags, so up and unlock
    strobe(2'h2, 8'h0, 16'h7);
    wait_req(1'h0);
    chk(o_error_output, 1'h0, "error low");
    repeat (6000) @(posedge i_mclk); // Poll slower than the reference
    strobe(2'h3, 8'h6D, 16'h0);
    chk(o_data_rdata, 4'h1, "unlock set");
    strobe(2'h2, 8'h0, 16'h3);
    strobe(2'h3, 8'h6D, 16'h0);
    strobe(2'h3, 8'h6D, 16'h0);
    chk(o_data_rdata, 4'h0, "unlock cleared");
    // Same value: direct gives ratio 40 (fast), lower swallow 640 (slow)
    @(posedge i_mclk);
    half <= 8'h4;
    strobe(2'h0, 8'h41, 16'h0280); // Direct ratio kept in range
    strobe(2'h2, 8'h0, 16'h7);
    wait_req(1'h1);
    chk(o_error_output, 1'h1, "error high");
    strobe(2'h2, 8'h0, 16'h3); // Stop so both dividers restart in step
    strobe(2'h2, 8'h0, 16'hB);
    wait_req(1'h0);
    chk(o_error_output_oe, 1'h1, "swallow ratio");
    chk(o_error_output, 1'h0, "swallow up");
    // CE low keeps mode, clock stop clears it
    @(posedge i_mclk);
    i_chip_enable <= 1'h0;
    repeat (8) @(posedge i_mclk);
    #1;
    chk(o_error_output_oe, 1'h0, "disabled pin");
    chk(o_up_request_n & o_down_request_n, 1'h1, "disabled requests");
    chk(o_mode_rdata, 4'hB, "mode kept");
    @(posedge i_mclk);
    i_chip_enable <= 1'h1;
    i_clock_stop <= 1'h1;
    @(posedge i_mclk);
    i_clock_stop <= 1'h0;
    repeat (2) @(posedge i_mclk);
    #1;
    chk(o_mode_rdata, 4'h0, "clock stop");
    print_verdict;
  end
endmodule // plsyn_core_tb
